// ==== logic/iec_checker.sv ====
// instruction exception checker with apb status and storage-limit registers
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module iec_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // instruction from decode and execute
   input wire logic req_valid_i,
   input iec_pkg::iec_req_s req_i,
   // outcome toward class interrupt logic
   output iec_pkg::iec_res_s res_o
);
   import iec_pkg::*;

   logic [15:0] status_q;
   logic [16:0] stor_limit_q;
   logic [15:0] last_iw_q;
   logic [15:0] last_cause_q;
   logic [1:0] last_class_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   iec_res_s s1_q;
   iec_res_s res_q;
   iec_res_s dec_d;
   logic [15:0] clr_mask;
   logic [4:0] op;
   logic beyond_instr, beyond_last, beyond_ea;
   logic err_stor, err_spec, err_priv, err_fn_pc, err_fn_st, err_stack, is_nop;

   // storage beyond installed size test
   function automatic logic beyond(input logic [15:0] a, input logic [16:0] lim);
      beyond = {1'b0, a} >= lim;
   endfunction

   // supervisor-state no-operation codes
   function automatic logic nop_code(input logic [15:0] iw);
      logic [4:0] o;
      o = iw[15:11];
      nop_code = ((o == OP_SYS) && (iw[3:0] == FN_NOP_A || iw[3:0] == FN_NOP_B ||
                                    iw[3:0] == FN_NOP_C || iw[3:0] == FN_NOP_D)) ||
                 ((o == OP_SHORT) && (iw[2:0] == FN_SHORT_NOP)) ||
                 ((o == OP_LONG) && (iw[4:0] == FN_LONG_A || iw[4:0] == FN_LONG_B));
   endfunction

   // privileged codes: the no-op set plus the four other system functions
   function automatic logic priv_code(input logic [15:0] iw);
      priv_code = nop_code(iw) ||
                  ((iw[15:11] == OP_SYS) && (iw[3:0] == FN_PC_A || iw[3:0] == FN_PC_B ||
                                             iw[3:0] == FN_ST_A || iw[3:0] == FN_ST_B));
   endfunction

   // exception detection from the presented instruction
   always_comb begin
      op = req_i.iw[15:11];
      beyond_instr = beyond(req_i.instr_addr, stor_limit_q);
      beyond_last = beyond(req_i.last_word_addr, stor_limit_q);
      beyond_ea = req_i.ea_used && beyond(req_i.ea, stor_limit_q);
      err_stor = beyond_instr || beyond_last || beyond_ea;
      err_spec = (req_i.ea_used && req_i.ea_even_req && req_i.ea[0]) ||
                 (req_i.ind_used && (req_i.addressing_mode_field == MODE_INDIRECT) && req_i.ind_addr[0]) ||
                 (req_i.supervisor_call && (req_i.call_status_ptr[0] || req_i.handler_start_pointer[0]));
      err_priv = !req_i.supervisor && priv_code(req_i.iw);
      err_fn_pc = req_i.undefined_fn ||
                  (req_i.supervisor && (op == OP_SYS) &&
                   (req_i.iw[3:0] == FN_PC_A || req_i.iw[3:0] == FN_PC_B)) ||
                  (req_i.supervisor && (op == OP_INV));
      err_fn_st = (op == OP_TRAP) ||
                  (req_i.supervisor && (op == OP_SYS) &&
                   (req_i.iw[3:0] == FN_ST_A || req_i.iw[3:0] == FN_ST_B)) ||
                  (!req_i.supervisor && (op == OP_INV));
      err_stack = ((req_i.push || req_i.store_multiple) && req_i.stack_full) ||
                  ((req_i.pop || req_i.load_multiple_branch) && req_i.stack_empty) ||
                  (req_i.store_multiple && (req_i.store_multiple_count > req_i.stack_free));
      is_nop = req_i.supervisor && nop_code(req_i.iw);
   end

   // fixed priority: storage, specification, privilege, function check, function trap, stack
   always_comb begin
      dec_d = '0;
      dec_d.valid = req_valid_i;
      dec_d.base_reg = req_i.base_register_field;
      if (err_stor) begin
         dec_d.prog_check = 1'b1;
         dec_d.cause[ST_STOR] = 1'b1;
         dec_d.terminate = req_i.terminate_on_storage;
         dec_d.suppress = !req_i.terminate_on_storage;
      end else if (err_spec) begin
         dec_d.prog_check = 1'b1;
         dec_d.cause[ST_SPEC] = 1'b1;
         dec_d.suppress = 1'b1;
      end else if (err_priv) begin
         dec_d.prog_check = 1'b1;
         dec_d.cause[ST_PRIV] = 1'b1;
         dec_d.suppress = 1'b1;
      end else if (err_fn_pc) begin
         dec_d.prog_check = 1'b1;
         dec_d.cause[ST_INVFN] = 1'b1;
         dec_d.suppress = 1'b1;
      end else if (err_fn_st) begin
         dec_d.soft_trap = 1'b1;
         dec_d.cause[ST_INVFN] = 1'b1;
         dec_d.suppress = 1'b1;
      end else if (err_stack) begin
         dec_d.soft_trap = 1'b1;
         dec_d.cause[ST_STACK] = 1'b1;
         dec_d.suppress = 1'b1;
         dec_d.base_inc = (req_i.addressing_mode_field == MODE_INCR);
      end else if (is_nop) begin
         dec_d.noop = 1'b1;
      end else begin
         dec_d.commit = 1'b1;
      end
      if (!req_valid_i) begin
         dec_d = '0;
      end
   end

   // first stage: decision captured while status is recorded
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_q <= '0;
      end else begin
         s1_q <= dec_d;
      end
   end

   // second stage: outcome driven one cycle after the status bit
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         res_q <= '0;
      end else begin
         res_q <= s1_q;
      end
   end
   assign res_o = res_q;

   // apb write-one-to-clear mask on the access edge
   always_comb begin
      clr_mask = '0;
      if (psel_i && penable_i && pready_q && pwrite_i && (paddr_i == REG_STATUS)) begin
         clr_mask = pwdata_i[15:0];
      end
   end

   // sticky status word, new cause wins over clear, undefined bits held zero
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_q <= ST_RESET;
      end else begin
         status_q <= ((status_q & ~clr_mask) | dec_d.cause) & ST_DEFINED_MASK;
      end
   end

   // installed storage size, software programmed
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stor_limit_q <= STOR_LIMIT_RESET;
      end else if (psel_i && penable_i && pready_q && pwrite_i && (paddr_i == REG_STOR_LIMIT)) begin
         stor_limit_q <= pwdata_i[16:0];
      end
   end

   // last excepted instruction and its class
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_iw_q <= '0;
         last_cause_q <= '0;
         last_class_q <= '0;
      end else if (dec_d.prog_check || dec_d.soft_trap) begin
         last_iw_q <= req_i.iw;
         last_cause_q <= dec_d.cause;
         last_class_q <= {dec_d.soft_trap, dec_d.prog_check};
      end
   end

   // apb handshake: ready in the access cycle, read data latched at setup
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else if (psel_i && !penable_i && !pready_q) begin
         pready_q <= 1'b1;
         pslverr_q <= 1'b0;
         case (paddr_i)
            REG_STATUS: begin
               prdata_q <= {16'h0000, status_q};
            end
            REG_STOR_LIMIT: begin
               prdata_q <= {15'h0000, stor_limit_q};
            end
            REG_LAST_EVENT: begin
               prdata_q <= {last_cause_q[7:0], 6'h00, last_class_q, last_iw_q};
            end
            default: begin
               prdata_q <= '0;
               pslverr_q <= 1'b1;
            end
         endcase
      end else begin
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end
   end
   assign pready_o = pready_q;
   assign prdata_o = prdata_q;
   assign pslverr_o = pslverr_q;

   // checks on the decided outcome
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_prog(logic [15:0] c);
      ##2 res_o.valid && res_o.prog_check && !res_o.soft_trap && (res_o.cause == c);
   endsequence

   sequence s_trap(logic [15:0] c);
      ##2 res_o.valid && res_o.soft_trap && !res_o.prog_check && (res_o.cause == c);
   endsequence

   a_storage_first: assert property (req_valid_i && err_stor |-> s_prog(16'h0002))
      else $error("storage violation not reported as program check bit 1");
   a_spec_odd_addr: assert property (req_valid_i && !err_stor && err_spec |-> s_prog(16'h0001))
      else $error("odd address not reported as specification check");
   a_priv_problem: assert property (req_valid_i && !err_stor && !err_spec && !req_i.supervisor &&
                                    priv_code(req_i.iw) |-> s_prog(16'h0004) ##0 res_o.suppress)
      else $error("privileged code in problem state not reported");
   a_invfn_check: assert property (req_valid_i && !err_stor && !err_spec && !err_priv &&
                                   req_i.undefined_fn |-> s_prog(16'h0010))
      else $error("undefined function not reported as program check");
   a_trap_opcode: assert property (req_valid_i && !err_stor && !err_spec && !err_priv && !err_fn_pc &&
                                   (req_i.iw[15:11] == OP_TRAP) |-> s_trap(16'h0010))
      else $error("trap opcode not reported as soft trap");
   a_stack_full: assert property (req_valid_i && !err_stor && !err_spec && !err_priv && !err_fn_pc &&
                                  !err_fn_st && req_i.push && req_i.stack_full |-> s_trap(16'h0040))
      else $error("push on full stack not trapped");
   a_base_incr: assert property (res_o.base_inc |-> res_o.soft_trap && res_o.cause[ST_STACK] &&
                                 $past(req_i.addressing_mode_field, 2) == MODE_INCR)
      else $error("base increment without mode 01 stack exception");
   a_noop_super: assert property (req_valid_i && req_i.supervisor && nop_code(req_i.iw) && !err_stor &&
                                  !err_spec && !err_stack |-> ##2 res_o.noop && !res_o.prog_check)
      else $error("supervisor no-op code not executed as no-op");
   a_suppress_none: assert property (res_o.suppress |-> !res_o.commit && !res_o.terminate)
      else $error("suppressed instruction also marked as completing");
   a_reserved_zero: assert property ((status_q & ~ST_DEFINED_MASK) == 16'h0000)
      else $error("undefined status bit set");
   a_status_before: assert property ((res_o.prog_check || res_o.soft_trap) |->
                                     ($past(status_q) & res_o.cause) == res_o.cause)
      else $error("class interrupt before status bit recorded");

   // remaining causes, each behind the causes that outrank it
   a_super_fn_check: assert property (req_valid_i && !err_stor && !err_spec && req_i.supervisor &&
                                      (op == OP_SYS) &&
                                      (req_i.iw[3:0] == FN_PC_A || req_i.iw[3:0] == FN_PC_B) |-> s_prog(16'h0010))
      else $error("supervisor system function not reported as program check");
   a_spec_indirect: assert property (req_valid_i && !err_stor && req_i.ind_used &&
                                     (req_i.addressing_mode_field == MODE_INDIRECT) && req_i.ind_addr[0] |->
                                     s_prog(16'h0001))
      else $error("odd indirect address not reported as specification check");
   a_spec_call: assert property (req_valid_i && !err_stor && req_i.supervisor_call &&
                                 (req_i.call_status_ptr[0] || req_i.handler_start_pointer[0]) |-> s_prog(16'h0001))
      else $error("odd call pointer not reported as specification check");
   a_super_fn_trap: assert property (req_valid_i && !err_stor && !err_spec && !err_fn_pc &&
                                     req_i.supervisor && (op == OP_SYS) &&
                                     (req_i.iw[3:0] == FN_ST_A || req_i.iw[3:0] == FN_ST_B) |-> s_trap(16'h0010))
      else $error("supervisor system function not trapped");
   a_inv_opcode: assert property (req_valid_i && !err_stor && !err_spec && !req_i.undefined_fn &&
                                  (op == OP_INV) |-> ##2 res_o.valid && (res_o.cause == 16'h0010) &&
                                  (res_o.prog_check == $past(req_i.supervisor, 2)) && res_o.suppress)
      else $error("invalid opcode not reported in the class for its state");
   a_stack_empty: assert property (req_valid_i && !err_stor && !err_spec && !err_priv && !err_fn_pc &&
                                   !err_fn_st && (req_i.pop || req_i.load_multiple_branch) && req_i.stack_empty
                                   |-> s_trap(16'h0040))
      else $error("pop on empty stack not trapped");
   a_stack_count: assert property (req_valid_i && !err_stor && !err_spec && !err_priv && !err_fn_pc &&
                                   !err_fn_st && req_i.store_multiple &&
                                   (req_i.store_multiple_count > req_i.stack_free) |-> s_trap(16'h0040))
      else $error("store multiple beyond free stack space not trapped");

   // outcome fields against the cause they carry
   a_storage_class: assert property (res_o.cause[ST_STOR] |-> res_o.prog_check && (res_o.suppress != res_o.terminate))
      else $error("storage cause without program check");
   a_spec_class: assert property (res_o.cause[ST_SPEC] |-> res_o.prog_check && res_o.suppress)
      else $error("specification cause not suppressed program check");
   a_priv_class: assert property (res_o.cause[ST_PRIV] |-> res_o.prog_check && res_o.suppress)
      else $error("privilege cause not suppressed program check");
   a_invfn_class: assert property (res_o.cause[ST_INVFN] |-> (res_o.prog_check || res_o.soft_trap) && res_o.suppress)
      else $error("invalid function cause not suppressed");
   a_stack_class: assert property (res_o.cause[ST_STACK] |-> res_o.soft_trap && res_o.suppress)
      else $error("stack cause not suppressed soft trap");
   a_trap_suppress: assert property (res_o.soft_trap |-> res_o.suppress && !res_o.commit &&
                                     !res_o.prog_check)
      else $error("soft trap without suppression");
   a_commit_clean: assert property (res_o.commit |-> (res_o.cause == 16'h0000) && !res_o.suppress &&
                                    !res_o.terminate && !res_o.noop)
      else $error("completing instruction carries a cause");
   a_noop_clean: assert property (res_o.noop |-> (res_o.cause == 16'h0000) && !res_o.suppress &&
                                  !res_o.soft_trap && !res_o.prog_check)
      else $error("no-op outcome carries an exception");
   a_terminate_stor: assert property (res_o.terminate |-> res_o.prog_check && (res_o.cause == 16'h0002))
      else $error("termination outside a storage violation");
   a_one_cause: assert property (res_o.valid |-> $onehot0(res_o.cause))
      else $error("more than one cause reported for one instruction");
   a_idle_quiet: assert property (!req_valid_i |-> ##2 !res_o.valid && (res_o.cause == 16'h0000))
      else $error("outcome without a presented instruction");
   a_base_reg_copy: assert property (res_o.base_inc |->
                                     res_o.base_reg == $past(req_i.base_register_field, 2))
      else $error("incremented base register is not the named one");
   a_status_set: assert property (req_valid_i |=> (status_q & $past(dec_d.cause)) == $past(dec_d.cause))
      else $error("status bit not recorded on the cycle after the check");
   a_status_sticky: assert property ((($past(status_q) & ~$past(clr_mask)) & ~status_q) == 16'h0000)
      else $error("status bit lost without a clear");
endmodule

// ==== logic/iec_pkg.sv ====
// package for the instruction exception checker: constants, register map, carriers
package iec_pkg;
   // status word bit positions (bit n of the register is status bit n)
   localparam int unsigned ST_SPEC = 0;
   localparam int unsigned ST_STOR = 1;
   localparam int unsigned ST_PRIV = 2;
   localparam int unsigned ST_INVFN = 4;
   localparam int unsigned ST_STACK = 6;
   localparam logic [15:0] ST_DEFINED_MASK = 16'h0057;
   localparam logic [15:0] ST_RESET = 16'h0000;

   // register map (byte addresses)
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_STOR_LIMIT = 8'h04;
   localparam logic [7:0] REG_LAST_EVENT = 8'h08;
   localparam logic [16:0] STOR_LIMIT_RESET = 17'h10000;

   // operation codes and function values
   localparam logic [4:0] OP_SYS = 5'h0b;
   localparam logic [4:0] OP_SHORT = 5'h0c;
   localparam logic [4:0] OP_LONG = 5'h0f;
   localparam logic [4:0] OP_TRAP = 5'h04;
   localparam logic [4:0] OP_INV = 5'h16;
   localparam logic [3:0] FN_PC_A = 4'h1;
   localparam logic [3:0] FN_PC_B = 4'h9;
   localparam logic [3:0] FN_ST_A = 4'h3;
   localparam logic [3:0] FN_ST_B = 4'hb;
   localparam logic [3:0] FN_NOP_A = 4'h2;
   localparam logic [3:0] FN_NOP_B = 4'h4;
   localparam logic [3:0] FN_NOP_C = 4'ha;
   localparam logic [3:0] FN_NOP_D = 4'hc;
   localparam logic [2:0] FN_SHORT_NOP = 3'h6;
   localparam logic [4:0] FN_LONG_A = 5'h12;
   localparam logic [4:0] FN_LONG_B = 5'h1a;
   localparam logic [1:0] MODE_INCR = 2'h1;
   localparam logic [1:0] MODE_INDIRECT = 2'h3;

   // one instruction presented for checking
   typedef struct packed {
      logic [15:0] iw;
      logic supervisor;
      logic [1:0] addressing_mode_field;
      logic [2:0] base_register_field;
      logic undefined_fn;
      logic [15:0] instr_addr;
      logic [15:0] last_word_addr;
      logic ea_used;
      logic ea_even_req;
      logic [15:0] ea;
      logic ind_used;
      logic [15:0] ind_addr;
      logic supervisor_call;
      logic [15:0] call_status_ptr;
      logic [15:0] handler_start_pointer;
      logic push;
      logic pop;
      logic store_multiple;
      logic load_multiple_branch;
      logic stack_full;
      logic stack_empty;
      logic [7:0] stack_free;
      logic [7:0] store_multiple_count;
      logic terminate_on_storage;
   } iec_req_s;

   // decided outcome of one instruction
   typedef struct packed {
      logic valid;
      logic prog_check;
      logic soft_trap;
      logic noop;
      logic suppress;
      logic terminate;
      logic commit;
      logic base_inc;
      logic [2:0] base_reg;
      logic [15:0] cause;
   } iec_res_s;
endpackage

// ==== tb/iec_decode_model.sv ====
// decode and execute side model that presents instructions to the checker
`timescale 1ns/1ns
module iec_decode_model (
   // clock
   input wire logic clk_i,
   // instruction toward the checker
   output logic req_valid_o,
   output iec_pkg::iec_req_s req_o
);
   import iec_pkg::*;
   // idle after time zero
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // one-cycle request; fields scrambled once released so stale data never looks valid
   task automatic issue(input iec_req_s r);
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_o <= r;
      @(posedge clk_i);
      req_valid_o <= 1'b0;
      req_o <= ~r;
   endtask
endmodule

// ==== tb/iec_checker_tb.sv ====
// self-checking bench for the instruction exception checker
`timescale 1ns/1ns
module iec_checker_tb;
   import iec_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic pready_o, pslverr_o, req_valid_i, er;
   logic [31:0] prdata_o, rd;
   iec_req_s req_i, b;
   iec_res_s res_o;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   // opcode, function, supervisor-state class
   logic [11:0] pl [11] = '{{OP_SYS, 5'h01, 2'h1}, {OP_SYS, 5'h09, 2'h1}, {OP_SYS, 5'h03, 2'h2},
      {OP_SYS, 5'h0b, 2'h2}, {OP_SYS, 5'h02, 2'h3}, {OP_SYS, 5'h04, 2'h3}, {OP_SYS, 5'h0a, 2'h3},
      {OP_SYS, 5'h0c, 2'h3}, {OP_SHORT, 5'h06, 2'h3}, {OP_LONG, 5'h12, 2'h3}, {OP_LONG, 5'h1a, 2'h3}};

   iec_checker u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .req_valid_i(req_valid_i), .req_i(req_i), .res_o(res_o));
   iec_decode_model u_model (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_o(req_i));

   // 10 mhz clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t word got %h expected %h", $time, got, exp);
      end
   endtask

   // base register only matters when an increment is asked for
   task automatic cmp_res(input iec_res_s got, input iec_res_s exp);
      if (!exp.base_inc)
         got.base_reg = exp.base_reg;
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t outcome got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n == 50)
         cmp_word(32'h0, 32'h1);
   endtask

   function automatic iec_req_s mk(input logic s, input logic [4:0] op, input logic [4:0] fn);
      iec_req_s r;
      r = '0;
      r.iw = {op, 6'h00, fn};
      r.supervisor = s;
      r.stack_free = 8'h10;
      r.base_register_field = 3'h5;
      return r;
   endfunction

   // class k: 0 commit, 1 program check, 2 soft trap, 3 no-op; bn cause bit, f for none
   task automatic run(input iec_req_s r, input logic [1:0] k, input logic [3:0] bn);
      iec_res_s e;
      e = '0;
      e.valid = 1'b1;
      e.prog_check = (k == 2'h1);
      e.soft_trap = (k == 2'h2);
      e.noop = (k == 2'h3);
      e.commit = (k == 2'h0);
      e.terminate = e.prog_check && r.terminate_on_storage;
      e.suppress = (e.prog_check || e.soft_trap) && !e.terminate;
      e.base_inc = (bn == 4'h6) && (r.addressing_mode_field == MODE_INCR);
      e.base_reg = r.base_register_field;
      if (bn != 4'hf)
         e.cause = 16'h1 << bn;
      u_model.issue(r);
      repeat (2) @(posedge clk_i);
      cmp_res(res_o, e);
      apb(1'b0, REG_STATUS, 32'h0);
      cmp_word(rd, {16'h0, e.cause});
      apb(1'b1, REG_STATUS, 32'hffff_ffff);
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      apb(1'b0, REG_STOR_LIMIT, 32'h0);
      cmp_word(rd, {15'h0, STOR_LIMIT_RESET});
      apb(1'b1, REG_STOR_LIMIT, 32'h8000);
      apb(1'b0, REG_STOR_LIMIT, 32'h0);
      cmp_word(rd, 32'h8000);
      apb(1'b0, 8'h0c, 32'h0);
      cmp_word({rd[30:0], er}, 32'h1);
      run(mk(1'b0, 5'h0e, 5'h00), 2'h0, 4'hf);
      foreach (pl[i]) begin
         run(mk(1'b0, pl[i][11:7], pl[i][6:2]), 2'h1, 4'h2);
         run(mk(1'b1, pl[i][11:7], pl[i][6:2]), pl[i][1:0], (pl[i][1:0] == 2'h3) ? 4'hf : 4'h4);
      end
      for (int s = 0; s < 2; s++) begin
         run(mk(s[0], OP_TRAP, 5'h00), 2'h2, 4'h4);
         run(mk(s[0], OP_INV, 5'h00), s[0] ? 2'h1 : 2'h2, 4'h4);
      end
      b = mk(1'b1, 5'h1a, 5'h00);
      b.undefined_fn = 1'b1;
      run(b, 2'h1, 4'h4);
      b = mk(1'b0, 5'h19, 5'h00);
      b.ea_used = 1'b1;
      b.ea_even_req = 1'b1;
      b.ea = 16'h0101;
      run(b, 2'h1, 4'h0);
      b.ea = 16'h0100;
      run(b, 2'h0, 4'hf);
      b.addressing_mode_field = MODE_INDIRECT;
      b.ind_used = 1'b1;
      b.ind_addr = 16'h0203;
      run(b, 2'h1, 4'h0);
      b.ea = 16'h8001;
      run(b, 2'h1, 4'h1);
      b = mk(1'b0, 5'h0e, 5'h00);
      b.instr_addr = 16'h7ffe;
      b.last_word_addr = 16'h7ffe;
      run(b, 2'h0, 4'hf);
      b.last_word_addr = 16'h8000;
      run(b, 2'h1, 4'h1);
      b.terminate_on_storage = 1'b1;
      run(b, 2'h1, 4'h1);
      b = mk(1'b1, 5'h0e, 5'h00);
      b.supervisor_call = 1'b1;
      b.call_status_ptr = 16'h0011;
      run(b, 2'h1, 4'h0);
      b.call_status_ptr = 16'h0010;
      b.handler_start_pointer = 16'h0021;
      run(b, 2'h1, 4'h0);
      b = mk(1'b0, OP_SYS, 5'h01);
      b.push = 1'b1;
      b.stack_full = 1'b1;
      run(b, 2'h1, 4'h2);
      b = mk(1'b0, 5'h0e, 5'h00);
      b.push = 1'b1;
      b.stack_full = 1'b1;
      run(b, 2'h2, 4'h6);
      b.push = 1'b0;
      b.store_multiple = 1'b1;
      b.addressing_mode_field = MODE_INCR;
      run(b, 2'h2, 4'h6);
      b = mk(1'b0, 5'h0e, 5'h00);
      b.stack_empty = 1'b1;
      b.pop = 1'b1;
      run(b, 2'h2, 4'h6);
      b.pop = 1'b0;
      b.load_multiple_branch = 1'b1;
      run(b, 2'h2, 4'h6);
      b = mk(1'b0, 5'h0e, 5'h00);
      b.store_multiple = 1'b1;
      b.store_multiple_count = 8'h10;
      run(b, 2'h0, 4'hf);
      b.store_multiple_count = 8'h11;
      run(b, 2'h2, 4'h6);
      apb(1'b0, REG_LAST_EVENT, 32'h0);
      cmp_word(rd & 32'hff03_ffff, {8'h40, 6'h00, 2'h2, b.iw});
      give_verdict();
   end
endmodule
